// [logic/ifu_pkg.sv]
// shared constants, types and index helpers of the instruction fetch unit
package ifu_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int          IFU_XLEN        = 32;
    localparam int          IFU_LEAD_CYCLES = 4;
    localparam int          IFU_PFB_DEPTH   = 4;
    localparam int          IFU_CNT_W       = 3;
    localparam logic [2:0]  IFU_PFB_FULL    = 3'h4;
    localparam int          IFU_WAYS        = 2;
    localparam int          IFU_WAY_WORDS   = 128;
    localparam int          IFU_SLOTS       = 64;
    localparam int          IFU_SET_W       = 6;
    localparam int          IFU_IDX_W       = 7;
    localparam int          IFU_WORD_LSB    = 2;
    localparam int          IFU_TAG_W       = IFU_XLEN - IFU_WORD_LSB;
    localparam int          IFU_PAGE_BITS   = 10;

    // ****************************************
    // block lengths, steps and reset values
    // ****************************************
    localparam logic [1:0]  IFU_LAST_BLK2   = 2'h1;
    localparam logic [1:0]  IFU_LAST_BLK4   = 2'h3;
    localparam logic [31:0] IFU_STEP        = 32'h4;
    localparam logic [31:0] IFU_SKIP_BLK2   = 32'h8;
    localparam logic [31:0] IFU_SKIP_BLK4   = 32'h10;
    localparam logic [31:0] IFU_PC_RESET    = 32'h0;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [0:0] {
        IFU_SRC_BUF   = 1'b0,
        IFU_SRC_CACHE = 1'b1
    } ifu_src_t;

    // ****************************************
    // target cache indexing
    // ****************************************
    function automatic logic [IFU_SET_W-1:0] ifu_set(input logic [IFU_XLEN-1:0] addr,
                                                     input logic            blk4);
        if (blk4) begin
            ifu_set = {1'b0, addr[IFU_WORD_LSB +: IFU_SET_W-1]};
        end else begin
            ifu_set = addr[IFU_WORD_LSB +: IFU_SET_W];
        end
    endfunction : ifu_set

    function automatic logic [IFU_IDX_W-1:0] ifu_base(input logic [IFU_SET_W-1:0] set,
                                                      input logic                 blk4);
        if (blk4) begin
            ifu_base = {set[IFU_SET_W-2:0], 2'h0};
        end else begin
            ifu_base = {set, 1'b0};
        end
    endfunction : ifu_base

endpackage : ifu_pkg

// [logic/ifu_fifo_if.sv]
// carrier between the fetch logic and its prefetch buffer
interface ifu_fifo_if #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int CW    = $clog2(DEPTH + 1)
);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;
    logic             flush;
    logic [CW-1:0]    count;

    modport fill (
        output wr_valid, wr_data, rd_ready, flush,
        input  wr_ready, rd_valid, rd_data, count
    );

    modport store (
        input  wr_valid, wr_data, rd_ready, flush,
        output wr_ready, rd_valid, rd_data, count
    );
endinterface : ifu_fifo_if

// [logic/ifu_fifo.sv]
// first-in first-out prefetch buffer with flush
module ifu_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic  i_clk,
    input wire logic  i_reset,
    // buffer ports
    ifu_fifo_if.store bus
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [CW-1:0]    cnt_reg;
    logic             wr_fire;
    logic             rd_fire;

    assign bus.wr_ready = (cnt_reg != CW'(DEPTH));
    assign bus.rd_valid = (cnt_reg != '0);
    assign bus.rd_data  = mem[rptr_reg];
    assign bus.count    = cnt_reg;
    assign wr_fire      = bus.wr_valid & bus.wr_ready & ~bus.flush;
    assign rd_fire      = bus.rd_ready & bus.rd_valid & ~bus.flush;

    // ****************************************
    // storage
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (wr_fire) begin
            mem[wptr_reg] <= bus.wr_data;
        end
    end

    // ****************************************
    // pointers and level
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset || bus.flush) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg  <= '0;
        end else begin
            if (wr_fire) begin
                wptr_reg <= AW'(wptr_reg + 1'b1);
            end
            if (rd_fire) begin
                rptr_reg <= AW'(rptr_reg + 1'b1);
            end
            cnt_reg <= CW'(cnt_reg + CW'(wr_fire) - CW'(rd_fire));
        end
    end

endmodule : ifu_fifo

// [logic/ifu_top.sv]
// instruction fetch unit: prefetch buffer, target cache and program counter
// Notes on behaviour
// - requests issued at least four cycles ahead
// - fetched instructions wait in four entries
// - free entry and enabled raises prefetch request
// - non-sequential fetch abandons stream, restarts at target
// - two-way target cache, 256 instructions total
// - software picks two or four per branch
// - cached target instructions feed decode first
// - cached branch target delivered without bubble
// - program counter tracks each delivered instruction
// - all fetch work ends in fetch stage
// - translate only at stream start, page crossing
module ifu_top
    import ifu_pkg::*;
(
    // clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_reset,
    // fetch control
    input  wire logic                i_fetch_en,
    input  wire logic                i_blk4,
    input  wire logic                i_branch,
    input  wire logic [IFU_XLEN-1:0] i_branch_target,
    // instruction memory channel
    output logic                     o_mem_req,
    output logic      [IFU_XLEN-1:0] o_mem_addr,
    output logic                     o_xlate_req,
    input  wire logic                i_mem_valid,
    input  wire logic [IFU_XLEN-1:0] i_mem_data,
    // decode stage
    output logic                     o_dec_valid,
    output logic      [IFU_XLEN-1:0] o_dec_instr,
    output logic      [IFU_XLEN-1:0] o_dec_pc,
    input  wire logic                i_dec_ready,
    // status
    output logic                     o_tc_hit,
    output logic                     o_hold
);

    // ****************************************
    // signals
    // ****************************************
    ifu_fifo_if #(.WIDTH(IFU_XLEN), .DEPTH(IFU_PFB_DEPTH)) pfb ();

    logic [IFU_XLEN-1:0]  cmem      [IFU_WAYS][IFU_WAY_WORDS];
    logic [IFU_TAG_W-1:0] tag_reg   [IFU_WAYS][IFU_SLOTS];
    logic                 valid_reg [IFU_WAYS][IFU_SLOTS];
    logic                 lru_reg   [IFU_SLOTS];
    logic                 mode_reg;
    logic                 mode_chg;
    logic [IFU_SET_W-1:0] lk_set;
    logic [IFU_WAYS-1:0]  way_hit;
    logic                 hit;
    logic                 hit_way;
    logic [1:0]           last_off;
    logic [IFU_XLEN-1:0]  skip;
    logic [IFU_XLEN-1:0]  hit_word;
    logic [IFU_XLEN-1:0]  pf_addr_reg;
    logic                 start_reg;
    logic [IFU_CNT_W-1:0] out_cnt_reg;
    logic [IFU_CNT_W-1:0] disc_cnt_reg;
    logic [IFU_CNT_W-1:0] occ;
    logic                 issue;
    logic                 resp_keep;
    logic                 fill_act_reg;
    logic                 fill_way_reg;
    logic [IFU_SET_W-1:0] fill_set_reg;
    logic [IFU_TAG_W-1:0] fill_tag_reg;
    logic [1:0]           fill_cnt_reg;
    logic                 fill_wr;
    logic                 fill_done;
    ifu_src_t             src_reg;
    logic                 csup_way_reg;
    logic [IFU_IDX_W-1:0] csup_base_reg;
    logic [1:0]           csup_cnt_reg;
    logic [IFU_XLEN-1:0]  csup_word;
    logic [IFU_XLEN-1:0]  nxt_pc_reg;
    logic                 adv;

    // ****************************************
    // prefetch buffer
    // ****************************************
    ifu_fifo #(
        .WIDTH (IFU_XLEN),
        .DEPTH (IFU_PFB_DEPTH)
    ) u_pfb (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .bus     (pfb)
    );

    assign resp_keep    = i_mem_valid & (disc_cnt_reg == '0) & ~i_branch;
    assign pfb.wr_valid = resp_keep;
    assign pfb.wr_data  = i_mem_data;
    assign pfb.flush    = i_branch;
    assign adv          = ~o_dec_valid | i_dec_ready;
    assign pfb.rd_ready = adv & ~i_branch & (src_reg == IFU_SRC_BUF);

    // ****************************************
    // target cache lookup
    // ****************************************
    assign mode_chg = (i_blk4 != mode_reg);
    assign lk_set   = ifu_set(i_branch_target, mode_reg);

    generate
        for (genvar w = 0; w < IFU_WAYS; w++) begin : g_way
            assign way_hit[w] = valid_reg[w][lk_set] &&
                (tag_reg[w][lk_set] == i_branch_target[IFU_XLEN-1:IFU_WORD_LSB]);
        end
    endgenerate

    assign hit       = (|way_hit) & ~mode_chg;
    assign hit_way   = ~way_hit[0];
    assign last_off  = mode_reg ? IFU_LAST_BLK4 : IFU_LAST_BLK2;
    assign skip      = mode_reg ? IFU_SKIP_BLK4 : IFU_SKIP_BLK2;
    assign hit_word  = cmem[hit_way][ifu_base(lk_set, mode_reg)];
    assign csup_word = cmem[csup_way_reg][IFU_IDX_W'(csup_base_reg + IFU_IDX_W'(csup_cnt_reg))];

    // ****************************************
    // prefetch request logic
    // ****************************************
    assign occ   = IFU_CNT_W'(out_cnt_reg - disc_cnt_reg + pfb.count);
    assign issue = i_fetch_en & ~i_branch & (occ < IFU_PFB_FULL) & pfb.wr_ready;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pf_addr_reg <= IFU_PC_RESET;
            start_reg   <= 1'b1;
            o_mem_req   <= 1'b0;
            o_mem_addr  <= IFU_PC_RESET;
            o_xlate_req <= 1'b0;
        end else begin
            o_mem_req   <= issue;
            o_xlate_req <= issue & (start_reg | (pf_addr_reg[IFU_PAGE_BITS-1:0] == '0));
            if (issue) begin
                o_mem_addr  <= pf_addr_reg;
                pf_addr_reg <= pf_addr_reg + IFU_STEP;
                start_reg   <= 1'b0;
            end
            if (i_branch) begin
                start_reg <= 1'b1;
                if (hit) begin
                    pf_addr_reg <= i_branch_target + skip;
                end else begin
                    pf_addr_reg <= i_branch_target;
                end
            end
        end
    end

    // ****************************************
    // in-flight and discard counts
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            out_cnt_reg  <= '0;
            disc_cnt_reg <= '0;
        end else begin
            out_cnt_reg <= IFU_CNT_W'(out_cnt_reg + IFU_CNT_W'(issue)
                                      - IFU_CNT_W'(i_mem_valid));
            if (i_branch) begin
                disc_cnt_reg <= IFU_CNT_W'(out_cnt_reg - IFU_CNT_W'(i_mem_valid));
            end else if (i_mem_valid && disc_cnt_reg != '0) begin
                disc_cnt_reg <= IFU_CNT_W'(disc_cnt_reg - 1'b1);
            end
        end
    end

    // ****************************************
    // miss refill control
    // ****************************************
    assign fill_wr   = fill_act_reg & resp_keep;
    assign fill_done = fill_wr & (fill_cnt_reg == last_off);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            fill_act_reg <= 1'b0;
            fill_way_reg <= 1'b0;
            fill_set_reg <= '0;
            fill_tag_reg <= '0;
            fill_cnt_reg <= '0;
        end else if (i_branch) begin
            fill_act_reg <= ~hit & ~mode_chg;
            fill_way_reg <= lru_reg[lk_set];
            fill_set_reg <= lk_set;
            fill_tag_reg <= i_branch_target[IFU_XLEN-1:IFU_WORD_LSB];
            fill_cnt_reg <= '0;
        end else if (mode_chg || fill_done) begin
            fill_act_reg <= 1'b0;
        end else if (fill_wr) begin
            fill_cnt_reg <= fill_cnt_reg + 2'h1;
        end
    end

    // ****************************************
    // target cache state
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mode_reg <= 1'b0;
        end else begin
            mode_reg <= i_blk4;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || mode_chg) begin
            for (int w = 0; w < IFU_WAYS; w++) begin
                for (int s = 0; s < IFU_SLOTS; s++) begin
                    valid_reg[w][s] <= 1'b0;
                end
            end
            for (int s = 0; s < IFU_SLOTS; s++) begin
                lru_reg[s] <= 1'b0;
            end
        end else begin
            if (i_branch && hit) begin
                lru_reg[lk_set] <= ~hit_way;
            end
            if (i_branch && !hit) begin
                valid_reg[lru_reg[lk_set]][lk_set] <= 1'b0;
            end
            if (fill_done) begin
                valid_reg[fill_way_reg][fill_set_reg] <= 1'b1;
                lru_reg[fill_set_reg]                 <= ~fill_way_reg;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (fill_wr) begin
            cmem[fill_way_reg][IFU_IDX_W'(ifu_base(fill_set_reg, mode_reg)
                                          + IFU_IDX_W'(fill_cnt_reg))] <= i_mem_data;
        end
        if (fill_done) begin
            tag_reg[fill_way_reg][fill_set_reg] <= fill_tag_reg;
        end
    end

    // ****************************************
    // decode output and program counter
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_dec_valid   <= 1'b0;
            o_dec_instr   <= '0;
            o_dec_pc      <= IFU_PC_RESET;
            nxt_pc_reg    <= IFU_PC_RESET;
            src_reg       <= IFU_SRC_BUF;
            csup_way_reg  <= 1'b0;
            csup_base_reg <= '0;
            csup_cnt_reg  <= '0;
            o_tc_hit      <= 1'b0;
        end else begin
            o_tc_hit <= i_branch & hit;
            if (i_branch) begin
                if (hit) begin
                    o_dec_valid   <= 1'b1;
                    o_dec_instr   <= hit_word;
                    o_dec_pc      <= i_branch_target;
                    nxt_pc_reg    <= i_branch_target + IFU_STEP;
                    src_reg       <= IFU_SRC_CACHE;
                    csup_way_reg  <= hit_way;
                    csup_base_reg <= ifu_base(lk_set, mode_reg);
                    csup_cnt_reg  <= 2'h1;
                end else begin
                    o_dec_valid <= 1'b0;
                    nxt_pc_reg  <= i_branch_target;
                    src_reg     <= IFU_SRC_BUF;
                end
            end else if (adv) begin
                case (src_reg)
                    IFU_SRC_CACHE: begin
                        o_dec_valid  <= 1'b1;
                        o_dec_instr  <= csup_word;
                        o_dec_pc     <= nxt_pc_reg;
                        nxt_pc_reg   <= nxt_pc_reg + IFU_STEP;
                        csup_cnt_reg <= csup_cnt_reg + 2'h1;
                        if (csup_cnt_reg == last_off) begin
                            src_reg <= IFU_SRC_BUF;
                        end
                    end
                    IFU_SRC_BUF: begin
                        o_dec_valid <= pfb.rd_valid;
                        if (pfb.rd_valid) begin
                            o_dec_instr <= pfb.rd_data;
                            o_dec_pc    <= nxt_pc_reg;
                            nxt_pc_reg  <= nxt_pc_reg + IFU_STEP;
                        end
                    end
                    default: begin
                        src_reg <= IFU_SRC_BUF;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // pipeline hold indication
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_hold <= 1'b0;
        end else begin
            o_hold <= i_fetch_en & ~i_branch & adv & (src_reg == IFU_SRC_BUF)
                      & ~pfb.rd_valid;
        end
    end

endmodule : ifu_top

// [bench/ifu_top_props.sv]
// port checker for the instruction fetch unit
module ifu_top_props
    import ifu_pkg::*;
(
    // clock and reset
    input wire logic                i_clk,
    input wire logic                i_reset,
    // fetch control
    input wire logic                i_fetch_en,
    input wire logic                i_blk4,
    input wire logic                i_branch,
    input wire logic [IFU_XLEN-1:0] i_branch_target,
    // instruction memory channel
    input wire logic                o_mem_req,
    input wire logic [IFU_XLEN-1:0] o_mem_addr,
    input wire logic                o_xlate_req,
    input wire logic                i_mem_valid,
    input wire logic [IFU_XLEN-1:0] i_mem_data,
    // decode stage
    input wire logic                o_dec_valid,
    input wire logic [IFU_XLEN-1:0] o_dec_instr,
    input wire logic [IFU_XLEN-1:0] o_dec_pc,
    input wire logic                i_dec_ready,
    // status
    input wire logic                o_tc_hit,
    input wire logic                o_hold
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // last request address and restart flag
    // ****************************************
    logic [IFU_XLEN-1:0] last_addr_reg;
    logic                restart_reg;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            restart_reg   <= 1'b1;
            last_addr_reg <= IFU_PC_RESET;
        end else if (i_branch) begin
            restart_reg <= 1'b1;
        end else if (o_mem_req) begin
            restart_reg   <= 1'b0;
            last_addr_reg <= o_mem_addr;
        end
    end

    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    property p_idle;
        !i_fetch_en |=> !o_mem_req;
    endproperty
    a_idle: assert property (p_idle) else $error("request while fetching disabled");

    // no request leaves in the cycle after the branch; the new stream's first request leaves two cycles after the branch
    property p_restart;
        i_branch && i_fetch_en ##1 !i_branch && i_fetch_en
            |=> o_mem_req && o_xlate_req && o_mem_addr == $past(i_branch_target, 2)
            + ($past(o_tc_hit) ? ($past(i_blk4, 2) ? IFU_SKIP_BLK4 : IFU_SKIP_BLK2) : 32'h0);
    endproperty
    a_restart: assert property (p_restart) else $error("stream not restarted at target");

    property p_seq;
        o_mem_req && !restart_reg |-> o_mem_addr == last_addr_reg + IFU_STEP;
    endproperty
    a_seq: assert property (p_seq) else $error("prefetch address not incremented");

    property p_xlate;
        o_mem_req && !restart_reg |-> o_xlate_req == (o_mem_addr[IFU_PAGE_BITS-1:0] == 10'h0);
    endproperty
    a_xlate: assert property (p_xlate) else $error("translation request misplaced");

    property p_dec_hold;
        o_dec_valid && !i_dec_ready && !i_branch
            |=> o_dec_valid && $stable(o_dec_instr) && $stable(o_dec_pc);
    endproperty
    a_dec_hold: assert property (p_dec_hold) else $error("decode word not held");

    property p_pc_seq;
        o_dec_valid && i_dec_ready && !i_branch ##1 o_dec_valid
            |-> o_dec_pc == $past(o_dec_pc) + IFU_STEP;
    endproperty
    a_pc_seq: assert property (p_pc_seq) else $error("program counter skipped");

    property p_hit;
        o_tc_hit |-> $past(i_branch) && o_dec_valid && o_dec_pc == $past(i_branch_target);
    endproperty
    a_hit: assert property (p_hit) else $error("cached target not presented");

    property p_kill;
        i_branch |=> o_tc_hit || !o_dec_valid;
    endproperty
    a_kill: assert property (p_kill) else $error("old word survived a branch");

    property p_hold;
        i_fetch_en && !i_branch |=> o_hold == !o_dec_valid;
    endproperty
    a_hold: assert property (p_hold) else $error("hold flag disagrees with decode output");

    c_hit:   cover property (o_tc_hit);
    c_miss:  cover property (i_branch ##1 !o_tc_hit);
    c_stall: cover property (o_dec_valid && !i_dec_ready [*3]);
endmodule : ifu_top_props

bind ifu_top ifu_top_props u_props (
    .i_clk(i_clk), .i_reset(i_reset), .i_fetch_en(i_fetch_en), .i_blk4(i_blk4),
    .i_branch(i_branch), .i_branch_target(i_branch_target), .o_mem_req(o_mem_req),
    .o_mem_addr(o_mem_addr), .o_xlate_req(o_xlate_req), .i_mem_valid(i_mem_valid),
    .i_mem_data(i_mem_data), .o_dec_valid(o_dec_valid), .o_dec_instr(o_dec_instr),
    .o_dec_pc(o_dec_pc), .i_dec_ready(i_dec_ready), .o_tc_hit(o_tc_hit), .o_hold(o_hold)
);

// [bench/ifu_mem_model.sv]
// instruction memory model answering in request order after a set latency
module ifu_mem_model (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // request side
    input  wire logic        i_req,
    input  wire logic [31:0] i_addr,
    input  wire logic [3:0]  i_lat,
    // answer side
    output logic             o_valid,
    output logic      [31:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] q_addr[$];
    int          q_due[$];
    int          cyc;
    logic [31:0] a;

    initial begin
        o_valid = 1'b0;
        o_data  = 32'h0;
        cyc     = 0;
    end

    // word content is a fixed pattern of its address; idle data toggles
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (i_reset) begin
            q_addr.delete();
            q_due.delete();
            o_valid <= 1'b0;
        end else begin
            if (i_req) begin
                q_addr.push_back(i_addr);
                q_due.push_back(cyc + int'(i_lat));
            end
            if (q_due.size() != 0 && q_due[0] <= cyc) begin
                a = q_addr.pop_front();
                void'(q_due.pop_front());
                o_valid <= 1'b1;
                o_data  <= {a[15:0], ~a[15:0]};
            end else begin
                o_valid <= 1'b0;
                o_data  <= ~o_data;
            end
        end
    end
endmodule : ifu_mem_model

// [bench/ifu_top_tb.sv]
// self-checking testbench of the instruction fetch unit
module ifu_top_tb
    import ifu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, reset, fetch_en, blk4, branch, dec_ready;
    logic [31:0] target;
    logic        mem_req, xlate_req, mem_valid, dec_valid, tc_hit;
    logic [31:0] mem_addr, mem_data, dec_instr, dec_pc;
    logic [3:0]  lat;
    int          compares, miscompares;

    initial clk = 1'b0;
    always #20 clk = ~clk;

    ifu_top DUT (
        .i_clk(clk), .i_reset(reset), .i_fetch_en(fetch_en), .i_blk4(blk4),
        .i_branch(branch), .i_branch_target(target), .o_mem_req(mem_req),
        .o_mem_addr(mem_addr), .o_xlate_req(xlate_req), .i_mem_valid(mem_valid),
        .i_mem_data(mem_data), .o_dec_valid(dec_valid), .o_dec_instr(dec_instr),
        .o_dec_pc(dec_pc), .i_dec_ready(dec_ready), .o_tc_hit(tc_hit), .o_hold()
    );

    ifu_mem_model mem (
        .i_clk(clk), .i_reset(reset), .i_req(mem_req), .i_addr(mem_addr),
        .i_lat(lat), .o_valid(mem_valid), .o_data(mem_data)
    );

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] word(input logic [31:0] a);
        word = {a[15:0], ~a[15:0]};
    endfunction : word

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic take(input logic [31:0] pc, input int n);
        for (int k = 0; k < 300 && n > 0; k++) begin
            if (dec_valid === 1'b1) begin
                chk("dec pc", pc, dec_pc);
                chk("dec word", word(pc), dec_instr);
                pc = pc + IFU_STEP;
                n--;
            end
            @(posedge clk);
            #1;
        end
        chk("words missing", 32'h0, 32'(n));
    endtask : take

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_stall;
        int n;
        n = 0;
        @(posedge clk);
        fetch_en <= 1'b1;
        for (int k = 0; k < 30; k++) begin
            @(posedge clk);
            #1;
            if (mem_req === 1'b1) begin
                chk("req addr", 32'(n) * IFU_STEP, mem_addr);
                chk("xlate", 32'(n == 0), 32'(xlate_req));
                n++;
            end
        end
        // buffer entries plus the decode output stage
        chk("requests while stalled", 32'(IFU_PFB_DEPTH + 1), 32'(n));
        @(posedge clk);
        dec_ready <= 1'b1;
        #1;
        take(32'h0, 12);
    endtask : t_stall

    task automatic t_disable;
        @(posedge clk);
        fetch_en <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            @(posedge clk);
            #1;
            if (k > 0) chk("req while disabled", 32'h0, 32'(mem_req));
        end
    endtask : t_disable

    task automatic t_branch(input logic [31:0] t, input logic hit);
        @(posedge clk);
        branch   <= 1'b1;
        target   <= t;
        fetch_en <= 1'b1;
        @(posedge clk);
        branch <= 1'b0;
        #1;
        chk("target hit", 32'(hit), 32'(tc_hit));
        take(t, 6);
    endtask : t_branch

    task automatic t_cache(input logic b, input logic [3:0] l);
        @(posedge clk);
        fetch_en <= 1'b0;
        lat      <= l;
        repeat (12) @(posedge clk);
        blk4 <= b;
        repeat (2) @(posedge clk);
        t_branch(32'h1000, 1'b0);
        t_branch(32'h1100, 1'b0);
        t_branch(32'h1000, 1'b1);
        t_branch(32'h1100, 1'b1);
        t_branch(32'h1200, 1'b0);
        t_branch(32'h1100, 1'b1);
        t_branch(32'h1000, 1'b0);
        t_branch(32'h03f8, 1'b0);
    endtask : t_cache

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        reset     = 1'b1;
        fetch_en  = 1'b0;
        blk4      = 1'b0;
        branch    = 1'b0;
        target    = 32'h0;
        dec_ready = 1'b0;
        lat       = 4'h1;
        compares    = 0;
        miscompares = 0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk("dec valid after reset", 32'h0, 32'(dec_valid));
        t_stall();
        t_disable();
        t_cache(1'b0, 4'h1);
        t_cache(1'b1, 4'h5);
        give_verdict();
    end

    initial begin
        #200us;
        miscompares++;
        give_verdict();
    end
endmodule : ifu_top_tb
